// File: opmode_consts.svh
// Constants for the operation mode and panel stop controller.
// Included by the design modules and the bench; definitions only.
`ifndef OPMODE_CONSTS_SVH
`define OPMODE_CONSTS_SVH

// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_PARAM 12'h004
`define OFF_STATUS 12'h008
`define OFF_IRQ_STAT 12'h00C
`define OFF_IRQ_MASK 12'h010
`define OFF_CMD 12'h014

// Parameter register field positions and reset values
`define P_MODE_LSB 0
`define P_STOPSEL_LSB 8
`define P_INV_BIT 12
`define P_ILK_ON_MRS_BIT 13
`define P_MODE_RST 8'h00
`define P_STOPSEL_RST 4'h0

// Mode-select settings used by the controller
`define MODE_SEL_SWITCH 8'h08
`define MODE_SEL_COMBINED 8'h03
`define MODE_SEL_INTERLOCK 8'h07

// Control register bits
`define C_COMM_BIT 0

// Status register bits
`define S_REMOTE_BIT 0
`define S_PS_BIT 1
`define S_ALARM_BIT 2
`define S_RUN_BIT 3
`define S_DETECT_BIT 4

// Interrupt event bits
`define I_MODE_BIT 0
`define I_PSTOP_BIT 1
`define I_ALARM_BIT 2

// Command register bits (write one to request)
`define K_COMM_REMOTE_BIT 0
`define K_COMM_PANEL_BIT 1

// Panel keys sampled as one-cycle pulses
`define MODE_PRESSES 2'h3

`endif

// File: opmode_ctrl.sv
// Operation mode arbitration, panel detach detection and panel stop control.
// Assumes all pins synchronous to pclk, key inputs are one-cycle pulses,
// and registers are reached over APB with zero wait states.
`timescale 1ns/1ns
`include "opmode_consts.svh"

module opmode_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Contact input terminals
    input wire logic local_remote_select,
    input wire logic panel_interlock,
    input wire logic output_stop_input,
    input wire logic forward_run_cmd,
    input wire logic reverse_run_cmd,
    // Operator panel
    input wire logic panel_present,
    input wire logic key_stop,
    input wire logic key_mode,
    input wire logic key_up,
    input wire logic key_set,
    input wire logic key_remote,
    // Motor output stage
    input wire logic output_active,
    output logic run_enable,
    output logic remote_mode,
    output logic panel_stop_indication,
    output logic panel_loss_alarm,
    output logic alarm_out,
    output logic irq
);

    // Software-visible state
    logic [7:0] mode_param_reg;
    logic [3:0] stopsel_reg;
    logic inv_reg;
    logic ilk_on_mrs_reg;
    logic comm_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;

    // Controller state
    logic remote_reg;
    logic ps_reg;
    logic ps_run_low_reg;
    logic alarm_reg;
    logic detect_en_reg;
    logic detect_cap_reg;

    logic wr;
    logic rd;
    logic run_any;
    logic motor_stopped;
    logic interlock_level;
    logic interlock_mode;
    logic want_remote;
    logic stop_valid;
    logic detach_evt;
    logic pstop_evt;
    logic ack_done;
    logic mode_chg;
    logic remote_next;
    logic comm_remote_req;
    logic comm_panel_req;
    logic [2:0] irq_evt;
    logic irq_clr;
    logic [31:0] ctrl_word;
    logic [31:0] param_word;
    logic [31:0] status_word;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    assign run_any = forward_run_cmd || reverse_run_cmd;
    assign motor_stopped = !run_any && !output_active;

    // Output-stop terminal takes the configured inversion when reused
    assign interlock_level = ilk_on_mrs_reg ? (output_stop_input ^ inv_reg)
                                            : panel_interlock;
    assign interlock_mode = (mode_param_reg == `MODE_SEL_INTERLOCK);

    assign comm_remote_req = wr && (paddr == `OFF_CMD)
                             && pwdata[`K_COMM_REMOTE_BIT];
    assign comm_panel_req = wr && (paddr == `OFF_CMD)
                            && pwdata[`K_COMM_PANEL_BIT];

    // Requested mode from terminals or from the communication commands
    always_comb
    begin
        want_remote = remote_reg;
        if (comm_reg)
        begin
            if (comm_remote_req)
                want_remote = 1'b1;
            else if (comm_panel_req)
                want_remote = 1'b0;
        end
        else if (mode_param_reg == `MODE_SEL_SWITCH)
        begin
            if (motor_stopped)
                want_remote = local_remote_select;
        end
        else if (interlock_mode)
            want_remote = !interlock_level;
    end

    always_comb
    begin
        remote_next = remote_reg;
        if (want_remote)
            remote_next = 1'b1;
        else if (!(interlock_mode && interlock_level && run_any))
            remote_next = 1'b0;
    end

    assign mode_chg = (remote_next != remote_reg);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            remote_reg <= 1'b0;
        else
            remote_reg <= remote_next;
    end

    // Detect enable is captured once after reset from panel presence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            detect_cap_reg <= 1'b0;
            detect_en_reg <= 1'b0;
        end
        else if (!detect_cap_reg)
        begin
            detect_cap_reg <= 1'b1;
            detect_en_reg <= panel_present;
        end
    end

    assign detach_evt = detect_en_reg && !panel_present && output_active
                        && stopsel_reg[0];

    // Settings 2 and 3 restrict the stop key to panel-related modes
    assign stop_valid = !stopsel_reg[1] || !remote_reg;
    assign pstop_evt = key_stop && stop_valid && run_any && !ps_reg;

    // Alarm stop is latched; only reset clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_reg <= 1'b0;
        else if (detach_evt)
            alarm_reg <= 1'b1;
    end

    panel_ack_seq panel_ack_seq_inst (
        .pclk(pclk),
        .presetn(presetn),
        .arm(ps_reg && ps_run_low_reg),
        .need_up(mode_param_reg == `MODE_SEL_COMBINED),
        .key_mode(key_mode),
        .key_up(key_up),
        .key_set(key_set),
        .key_remote(key_remote),
        .done(ack_done)
    );

    // Panel stop holds until run dropped, sequence acked; run then restarts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ps_reg <= 1'b0;
            ps_run_low_reg <= 1'b0;
        end
        else if (pstop_evt)
        begin
            ps_reg <= 1'b1;
            ps_run_low_reg <= 1'b0;
        end
        else if (ps_reg)
        begin
            if (!run_any)
                ps_run_low_reg <= 1'b1;
            if (ack_done)
                ps_reg <= 1'b0;
        end
    end

    assign run_enable = run_any && !ps_reg && !alarm_reg;
    assign remote_mode = remote_reg;
    assign panel_stop_indication = ps_reg && remote_reg;
    assign panel_loss_alarm = alarm_reg;
    assign alarm_out = alarm_reg;

    // Parameter register fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_param_reg <= `P_MODE_RST;
            stopsel_reg <= `P_STOPSEL_RST;
            inv_reg <= 1'b0;
            ilk_on_mrs_reg <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == `OFF_PARAM)
            begin
                mode_param_reg <= pwdata[`P_MODE_LSB +: 8];
                stopsel_reg <= pwdata[`P_STOPSEL_LSB +: 4];
                inv_reg <= pwdata[`P_INV_BIT];
                ilk_on_mrs_reg <= pwdata[`P_ILK_ON_MRS_BIT];
            end
        end
    end

    // Serial control flag kept apart from the drive parameters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            comm_reg <= 1'b0;
        else if (wr && (paddr == `OFF_CTRL))
            comm_reg <= pwdata[`C_COMM_BIT];
    end

    always_comb
    begin
        irq_evt = 3'h0;
        irq_evt[`I_MODE_BIT] = mode_chg;
        irq_evt[`I_PSTOP_BIT] = pstop_evt;
        // Detach is a level; flag only its first cycle so a clear can stick
        irq_evt[`I_ALARM_BIT] = detach_evt && !alarm_reg;
    end

    assign irq_clr = wr && (paddr == `OFF_IRQ_STAT);

    // Sticky events: set wins over a write-one clear in the same cycle
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_irq
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    irq_stat_reg[i] <= 1'b0;
                else if (irq_evt[i])
                    irq_stat_reg[i] <= 1'b1;
                else if (irq_clr && pwdata[i])
                    irq_stat_reg[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= 3'h0;
        else if (wr && (paddr == `OFF_IRQ_MASK))
            irq_mask_reg <= pwdata[2:0];
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read words built from the field positions so the layout lives in one place
    always_comb
    begin
        ctrl_word = 32'h00000000;
        ctrl_word[`C_COMM_BIT] = comm_reg;
    end

    always_comb
    begin
        param_word = 32'h00000000;
        param_word[`P_MODE_LSB +: 8] = mode_param_reg;
        param_word[`P_STOPSEL_LSB +: 4] = stopsel_reg;
        param_word[`P_INV_BIT] = inv_reg;
        param_word[`P_ILK_ON_MRS_BIT] = ilk_on_mrs_reg;
    end

    always_comb
    begin
        status_word = 32'h00000000;
        status_word[`S_REMOTE_BIT] = remote_reg;
        status_word[`S_PS_BIT] = ps_reg;
        status_word[`S_ALARM_BIT] = alarm_reg;
        status_word[`S_RUN_BIT] = run_enable;
        status_word[`S_DETECT_BIT] = detect_en_reg;
    end

    // Read data registered in the setup phase, valid through the access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd)
        begin
            case (paddr)
                `OFF_CTRL:
                    prdata <= ctrl_word;
                `OFF_PARAM:
                    prdata <= param_word;
                `OFF_STATUS:
                    prdata <= status_word;
                `OFF_IRQ_STAT:
                    prdata <= {29'h00000000, irq_stat_reg};
                `OFF_IRQ_MASK:
                    prdata <= {29'h00000000, irq_mask_reg};
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

endmodule : opmode_ctrl

// File: opmode_ctrl_properties.sv
// Output relations of the operation mode controller.
// Sees only the top ports; one clock domain, pclk, async presetn.
`timescale 1ns/1ns

module opmode_ctrl_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Terminal and panel inputs
    input wire logic panel_interlock,
    input wire logic forward_run_cmd,
    input wire logic reverse_run_cmd,
    input wire logic panel_present,
    input wire logic output_active,
    // Outputs
    input wire logic run_enable,
    input wire logic remote_mode,
    input wire logic panel_stop_indication,
    input wire logic panel_loss_alarm,
    input wire logic alarm_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire run_any = forward_run_cmd | reverse_run_cmd;

    property p_alarm_pin; alarm_out == panel_loss_alarm; endproperty
    a_alarm_pin: assert property (p_alarm_pin)
        else $error("alarm pin differs");
    property p_loss_sticky; panel_loss_alarm |=> panel_loss_alarm; endproperty
    a_loss_sticky: assert property (p_loss_sticky)
        else $error("loss alarm dropped");
    property p_detach;
        $rose(panel_loss_alarm) |-> $past(output_active) && !$past(panel_present);
    endproperty
    a_detach: assert property (p_detach)
        else $error("loss alarm without detach");
    property p_ilk_hold;
        remote_mode && panel_interlock && run_any |=> remote_mode;
    endproperty
    a_ilk_hold: assert property (p_ilk_hold)
        else $error("panel mode entered while running");
    property p_run_gate; run_enable |-> run_any; endproperty
    a_run_gate: assert property (p_run_gate)
        else $error("run without command");
    property p_alarm_stop; alarm_out |-> !run_enable; endproperty
    a_alarm_stop: assert property (p_alarm_stop)
        else $error("run during alarm");
    property p_ps_stop; panel_stop_indication |-> !run_enable; endproperty
    a_ps_stop: assert property (p_ps_stop)
        else $error("run during panel stop");
    property p_ps_remote; panel_stop_indication |-> remote_mode; endproperty
    a_ps_remote: assert property (p_ps_remote)
        else $error("stop shown in panel mode");
    property p_ps_quiet;
        $rose(panel_stop_indication) |-> !$rose(alarm_out);
    endproperty
    a_ps_quiet: assert property (p_ps_quiet)
        else $error("alarm with panel stop");

    c_ps: cover property ($rose(panel_stop_indication));
    c_alarm: cover property ($rose(panel_loss_alarm));
    c_remote: cover property ($rose(remote_mode));
endmodule : opmode_ctrl_properties

bind opmode_ctrl opmode_ctrl_properties opmode_ctrl_properties_inst (
    .pclk(pclk),
    .presetn(presetn),
    .panel_interlock(panel_interlock),
    .forward_run_cmd(forward_run_cmd),
    .reverse_run_cmd(reverse_run_cmd),
    .panel_present(panel_present),
    .output_active(output_active),
    .run_enable(run_enable),
    .remote_mode(remote_mode),
    .panel_stop_indication(panel_stop_indication),
    .panel_loss_alarm(panel_loss_alarm),
    .alarm_out(alarm_out)
);

// File: opmode_pkg.sv
// Types shared by the operation mode controller files.
// Constants live in opmode_consts.svh.
package opmode_pkg;

    typedef enum logic [1:0] {
        ACK_IDLE = 2'b00,
        ACK_MODE = 2'b01,
        ACK_UP = 2'b10,
        ACK_SET = 2'b11
    } ack_state_t;

endpackage : opmode_pkg

// File: panel_ack_seq.sv
// Panel acknowledge key sequence recogniser for restart after a panel stop.
// Assumes key inputs are one-cycle pulses synchronous to pclk.
`timescale 1ns/1ns
`include "opmode_consts.svh"

module panel_ack_seq (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic arm,
    input wire logic need_up,
    // Panel keys
    input wire logic key_mode,
    input wire logic key_up,
    input wire logic key_set,
    input wire logic key_remote,
    // Result
    output logic done
);

    opmode_pkg::ack_state_t state_reg;
    logic [1:0] cnt_reg;

    // A stray mode, up or set key restarts the count; remote is ignored once past idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= opmode_pkg::ACK_IDLE;
            cnt_reg <= 2'h0;
        end
        else if (!arm)
        begin
            state_reg <= opmode_pkg::ACK_IDLE;
            cnt_reg <= 2'h0;
        end
        else
        begin
            case (state_reg)
                opmode_pkg::ACK_IDLE:
                begin
                    cnt_reg <= 2'h0;
                    if (key_remote)
                        state_reg <= opmode_pkg::ACK_SET;
                    else if (key_mode)
                    begin
                        cnt_reg <= 2'h1;
                        state_reg <= opmode_pkg::ACK_MODE;
                    end
                end
                opmode_pkg::ACK_MODE:
                begin
                    if (key_mode)
                    begin
                        cnt_reg <= cnt_reg + 2'h1;
                        if (cnt_reg + 2'h1 == `MODE_PRESSES)
                            state_reg <= need_up ? opmode_pkg::ACK_UP
                                                 : opmode_pkg::ACK_SET;
                    end
                    else if (key_up || key_set)
                        state_reg <= opmode_pkg::ACK_IDLE;
                end
                opmode_pkg::ACK_UP:
                begin
                    if (key_up)
                        state_reg <= opmode_pkg::ACK_SET;
                    else if (key_mode || key_set)
                        state_reg <= opmode_pkg::ACK_IDLE;
                end
                opmode_pkg::ACK_SET:
                begin
                    if (key_set || key_mode || key_up)
                        state_reg <= opmode_pkg::ACK_IDLE;
                end
                default:
                    state_reg <= opmode_pkg::ACK_IDLE;
            endcase
        end
    end

    assign done = arm && (state_reg == opmode_pkg::ACK_SET) && key_set;

endmodule : panel_ack_seq

// File: panel_model.sv
// Operator panel stand-in: turns bench requests into one-cycle key pulses.
// Assumes the bench raises press for exactly one pclk cycle per key.
`timescale 1ns/1ns

module panel_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request from the bench: 0 stop, 1 mode, 2 up, 3 set, 4 remote
    input wire logic press,
    input wire logic [2:0] key_code,
    // Key pulses
    output logic key_stop,
    output logic key_mode,
    output logic key_up,
    output logic key_set,
    output logic key_remote
);
    // A real panel never holds two keys at once, so one hot per press
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {key_stop, key_mode, key_up, key_set, key_remote} <= 5'h00;
        else
            {key_stop, key_mode, key_up, key_set, key_remote} <=
                press ? (5'h10 >> key_code) : 5'h00;
    end
endmodule : panel_model

// File: tb_opmode_ctrl.sv
// Self-checking bench for opmode_ctrl with the panel model on the keys.
// Assumes zero-wait APB and registered mode updates.
`timescale 1ns/1ns
`include "opmode_consts.svh"

module tb_opmode_ctrl;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, press;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic local_remote_select, panel_interlock, output_stop_input;
    logic forward_run_cmd, reverse_run_cmd, panel_present, output_active;
    logic key_stop, key_mode, key_up, key_set, key_remote;
    logic [2:0] key_code;
    logic run_enable, remote_mode, panel_stop_indication;
    logic panel_loss_alarm, alarm_out, irq;
    int fails, compares, cycles;

    opmode_ctrl opmode_ctrl_inst (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .local_remote_select(local_remote_select),
        .panel_interlock(panel_interlock),
        .output_stop_input(output_stop_input),
        .forward_run_cmd(forward_run_cmd),
        .reverse_run_cmd(reverse_run_cmd),
        .panel_present(panel_present),
        .key_stop(key_stop),
        .key_mode(key_mode),
        .key_up(key_up),
        .key_set(key_set),
        .key_remote(key_remote),
        .output_active(output_active),
        .run_enable(run_enable),
        .remote_mode(remote_mode),
        .panel_stop_indication(panel_stop_indication),
        .panel_loss_alarm(panel_loss_alarm),
        .alarm_out(alarm_out),
        .irq(irq)
    );
    panel_model panel_model_inst (
        .pclk(pclk),
        .presetn(presetn),
        .press(press),
        .key_code(key_code),
        .key_stop(key_stop),
        .key_mode(key_mode),
        .key_up(key_up),
        .key_set(key_set),
        .key_remote(key_remote)
    );

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // Generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            end_sim();
        end
    end

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task key(input logic [2:0] c);
        press <= 1'b1;
        key_code <= c;
        @(posedge pclk);
        press <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : key

    task t_regs;
        apb(1'b0, `OFF_PARAM, 32'h0);
        chk("param", rd, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("slverr", pslverr, 32'h0);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk("detect", rd[`S_DETECT_BIT], 32'h1);
        apb(1'b1, `OFF_IRQ_MASK, 32'h7);
        $display("regs done");
    endtask : t_regs

    task t_switch;
        apb(1'b1, `OFF_PARAM, 32'h8);
        local_remote_select <= 1'b1;
        cyc(3);
        chk("remote", remote_mode, 32'h1);
        forward_run_cmd <= 1'b1;
        local_remote_select <= 1'b0;
        cyc(3);
        chk("hold_run", remote_mode, 32'h1);
        forward_run_cmd <= 1'b0;
        output_active <= 1'b1;
        cyc(3);
        chk("hold_out", remote_mode, 32'h1);
        output_active <= 1'b0;
        cyc(3);
        chk("panel", remote_mode, 32'h0);
        $display("switch done");
    endtask : t_switch

    task t_ilk;
        apb(1'b1, `OFF_PARAM, 32'h7);
        cyc(3);
        chk("ilk_off", remote_mode, 32'h1);
        reverse_run_cmd <= 1'b1;
        panel_interlock <= 1'b1;
        cyc(3);
        chk("ilk_refuse", remote_mode, 32'h1);
        reverse_run_cmd <= 1'b0;
        cyc(3);
        chk("ilk_panel", remote_mode, 32'h0);
        reverse_run_cmd <= 1'b1;
        panel_interlock <= 1'b0;
        cyc(3);
        chk("ilk_release", remote_mode, 32'h1);
        chk("ilk_run", run_enable, 32'h1);
        reverse_run_cmd <= 1'b0;
        apb(1'b1, `OFF_PARAM, 32'h3007);
        cyc(3);
        chk("inv_panel", remote_mode, 32'h0);
        output_stop_input <= 1'b1;
        cyc(3);
        chk("inv_remote", remote_mode, 32'h1);
        $display("interlock done");
    endtask : t_ilk

    task t_pstop;
        local_remote_select <= 1'b1;
        apb(1'b1, `OFF_PARAM, 32'h208);
        forward_run_cmd <= 1'b1;
        cyc(3);
        key(3'h0);
        chk("stop_ignored", run_enable, 32'h1);
        apb(1'b1, `OFF_PARAM, 32'h8);
        key(3'h0);
        chk("ps", panel_stop_indication, 32'h1);
        chk("ps_run", run_enable, 32'h0);
        chk("ps_alarm", alarm_out, 32'h0);
        chk("irq", irq, 32'h1);
        apb(1'b1, `OFF_IRQ_MASK, 32'h0);
        cyc(1);
        chk("irq_masked", irq, 32'h0);
        apb(1'b1, `OFF_IRQ_MASK, 32'h7);
        apb(1'b1, `OFF_IRQ_STAT, 32'h7);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk("irq_clear", rd, 32'h0);
        forward_run_cmd <= 1'b0;
        repeat (3) key(3'h1);
        key(3'h3);
        chk("ps_ack", panel_stop_indication, 32'h0);
        forward_run_cmd <= 1'b1;
        cyc(2);
        chk("restart", run_enable, 32'h1);
        apb(1'b1, `OFF_PARAM, 32'h3);
        key(3'h0);
        forward_run_cmd <= 1'b0;
        repeat (3) key(3'h1);
        key(3'h3);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk("no_up", rd[`S_PS_BIT], 32'h1);
        repeat (3) key(3'h1);
        key(3'h2);
        key(3'h3);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk("with_up", rd[`S_PS_BIT], 32'h0);
        forward_run_cmd <= 1'b1;
        cyc(2);
        key(3'h0);
        chk("ps_again", panel_stop_indication, 32'h1);
        forward_run_cmd <= 1'b0;
        key(3'h4);
        key(3'h3);
        chk("remote_key_ack", panel_stop_indication, 32'h0);
        $display("panel stop done");
    endtask : t_pstop

    task t_comm;
        apb(1'b1, `OFF_CTRL, 32'h1);
        apb(1'b1, `OFF_CMD, 32'h2);
        cyc(2);
        chk("comm_panel", remote_mode, 32'h0);
        apb(1'b1, `OFF_CMD, 32'h1);
        cyc(2);
        chk("comm_remote", remote_mode, 32'h1);
        apb(1'b1, `OFF_CTRL, 32'h0);
        $display("comm done");
    endtask : t_comm

    task t_detach;
        logic [3:0] sel [3];
        sel = '{4'h0, 4'h2, 4'h1};
        forward_run_cmd <= 1'b1;
        output_active <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, `OFF_PARAM, {20'h0, sel[i], 8'h08});
            panel_present <= 1'b0;
            cyc(3);
            chk("loss", panel_loss_alarm, {31'h0, sel[i][0]});
            chk("loss_run", run_enable, {31'h0, !sel[i][0]});
            panel_present <= 1'b1;
        end
        cyc(1);
        panel_present <= 1'b0;
        apb(1'b1, `OFF_IRQ_STAT, 32'h7);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk("irq_once", rd, 32'h0);
        presetn <= 1'b0;
        panel_present <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(2);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk("no_detect", rd[`S_DETECT_BIT], 32'h0);
        apb(1'b1, `OFF_PARAM, 32'h108);
        cyc(3);
        chk("no_loss", panel_loss_alarm, 32'h0);
        $display("detach done");
    endtask : t_detach

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, press, paddr, pwdata, key_code} = '0;
        {local_remote_select, panel_interlock, output_stop_input} = 3'h0;
        {forward_run_cmd, reverse_run_cmd, output_active} = 3'h0;
        panel_present = 1'b1;
        cyc(8);
        presetn <= 1'b1;
        t_regs();
        t_switch();
        t_ilk();
        t_pstop();
        t_comm();
        t_detach();
        end_sim();
    end
endmodule : tb_opmode_ctrl
